/* bench/spi_host_model.sv */
// Host SPI master model: 32-bit mode 0 frames, MSB first.
// Assumes clk_sys oversamples sclk; each phase lasts two cycles.
`timescale 1ns/1ps

module spi_host_model
(
	input wire logic clk_sys,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	// =====================================
	// Idle levels
	initial
	begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// =====================================
	// One frame, response sampled at each sclk rise
	task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
		@(negedge clk_sys);
		spi_cs_n = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			spi_mosi = cmd[i];
			repeat (2) @(negedge clk_sys);
			resp[i] = spi_miso;
			spi_sclk = 1'b1;
			repeat (2) @(negedge clk_sys);
			spi_sclk = 1'b0;
		end
		repeat (2) @(negedge clk_sys);
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi; // Released line shows no stale bit
		repeat (3) @(negedge clk_sys);
	endtask : xfer
endmodule : spi_host_model

/* bench/test_switch_monitor_lpm_analog_mux_output_regs.sv */
// Self-checking bench for the switch monitor register slice.
// Assumes spi_host_model as SPI master and a short debounce extension.
`timescale 1ns/1ps

module test_switch_monitor_lpm_analog_mux_output_regs;
	import switch_monitor_pkg::*;

	// =====================================
	// Signals and constants
	localparam int EXT = 16;
	localparam logic [5:0] CODES [9] = '{6'h00, 6'h01, 6'h15, 6'h16, 6'h21, 6'h22, 6'h23, 6'h24, 6'h3f};
	logic clk_sys, rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	logic [GND_CH-1:0] ground_switch_inputs, gnd_wake_debounce;
	logic [PRG_CH-1:0] programmable_switch_inputs;
	logic [7:0] fault_flags;
	logic interrupt_event, wake_event, poll_window_end, low_power_mode, poll_extend;
	logic meas_diff_strobe, meas_level_strobe, wetting_current_en, interrupt_flag_bit;
	logic [ANALOG_MUX_OUTPUT_SRC-1:0] analog_mux_output_sel;
	logic [6:0] pa;
	logic prw, iexp;
	logic [21:0] pd;
	int error_cnt = 0;
	int checked = 0;
	int oe_cnt = 0;

	// Design and host model
	switch_monitor_lpm_analog_mux_output_regs #(.FAULT_W(8), .EXTEND_CYCLES(EXT)) switch_monitor_lpm_analog_mux_output_regs_i
	(
		.clk_sys, .rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
		.ground_switch_inputs, .programmable_switch_inputs, .fault_flags, .interrupt_event,
		.wake_event, .poll_window_end, .low_power_mode, .poll_extend, .meas_diff_strobe,
		.meas_level_strobe, .gnd_wake_debounce, .analog_mux_output_sel, .wetting_current_en,
		.interrupt_flag_bit
	);
	spi_host_model spi_host_model_i
	(
		.clk_sys, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso
	);

	// Clock, 8 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Cycles with the data output driver on
	always @(negedge clk_sys)
	begin
		if (spi_miso_oe === 1'b1)
			oe_cnt++;
	end

	// =====================================
	// Helpers
	task automatic chk(input string name, input logic [34:0] seen, input logic [34:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Frame whose answer is the previous command's result
	task automatic op(input logic [6:0] a, input logic rw, input logic [23:0] d, input logic [21:0] nd,
		input string name);
		logic [31:0] r;
		spi_host_model_i.xfer({a, rw, d}, r);
		chk(name, r, {pa, prw, |fault_flags, iexp, pd});
		pa = a;
		prw = rw;
		pd = nd;
		iexp = 1'b0;
	endtask : op

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	// =====================================
	// Scenarios
	task automatic t_reset;
		chk("lpm", low_power_mode, 0);
		chk("deb", gnd_wake_debounce, 0);
		chk("sel", analog_mux_output_sel, 0);
		chk("wet", wetting_current_en, 0);
		chk("int", interrupt_flag_bit, 1);
		chk("oe_rst", spi_miso_oe, 0);
	endtask : t_reset

	task automatic t_first;
		op(ADDR_PRG_STATUS, 1'b0, 24'h00_0000, {10'h000, programmable_switch_inputs}, "first");
		chk("int_clr", interrupt_flag_bit, 0);
		chk("oe_frame", oe_cnt != 0, 1);
		fault_flags = 8'h00;
	endtask : t_first

	task automatic t_deb;
		op(ADDR_GND_DEBOUNCE, 1'b1, 24'hff_ffff, 22'h1f_ffff, "deb_wr");
		chk("deb_val", gnd_wake_debounce, 21'h1f_ffff);
		chk("ext_norm", poll_extend, 0);
		fault_flags = 8'h01;
		op(ADDR_GND_DEBOUNCE, 1'b0, 24'h00_0000, 22'h1f_ffff, "deb_rd");
	endtask : t_deb

	task automatic t_analog_mux_output;
		logic [5:0] c;
		logic cur;
		for (int k = 0; k < 9; k++)
		begin
			c = CODES[k];
			cur = k[0];
			op(ADDR_ANALOG_MUX_OUTPUT_CTRL, 1'b1, {17'h1_ffff, cur, c}, {15'h0000, cur, c}, "analog_mux_output");
			chk("sel", analog_mux_output_sel, (c >= 1 && c <= 35) ? 35'h1 << (c - 1) : 35'h0);
			chk("wet", wetting_current_en, cur && c >= 1 && c <= 33);
		end
	endtask : t_analog_mux_output

	task automatic t_mask;
		op(ADDR_ANALOG_MUX_OUTPUT_CTRL, 1'b1, 24'h00_0006, 22'h00_0006, "sel5");
		interrupt_event = 1'b1;
		@(negedge clk_sys);
		interrupt_event = 1'b0;
		@(negedge clk_sys);
		chk("int_set", interrupt_flag_bit, 1);
		iexp = 1'b1;
		op(ADDR_GND_STATUS, 1'b0, 24'h00_0000, {1'b0, ground_switch_inputs & ~21'h00_0020}, "stat");
		op(ADDR_ANALOG_MUX_OUTPUT_CTRL, 1'b0, 24'h00_0000, 22'h00_0006, "rd_sel");
	endtask : t_mask

	task automatic t_lpm;
		int n;
		int o;
		logic sd;
		logic [31:0] r;
		op(ADDR_LPM_ENTRY, 1'b1, 24'h00_0001, 22'h00_0000, "lpm_bad");
		chk("lpm_bad", low_power_mode, 0);
		op(ADDR_LPM_ENTRY, 1'b1, 24'h00_0000, 22'h00_0000, "lpm");
		chk("lpm_on", low_power_mode, 1);
		chk("oe", spi_miso_oe, 0);
		// A frame in low power must change nothing
		o = oe_cnt;
		spi_host_model_i.xfer({ADDR_GND_DEBOUNCE, 1'b1, 24'h00_0000}, r);
		chk("lpm_frame", gnd_wake_debounce, 21'h1f_ffff);
		chk("lpm_kept", low_power_mode, 1);
		chk("oe_lpm", oe_cnt - o, 0);
		poll_window_end = 1'b1;
		@(negedge clk_sys);
		poll_window_end = 1'b0;
		sd = 1'b0;
		for (n = 0; n < 4 && poll_extend !== 1'b1; n++)
		begin
			sd = sd | meas_diff_strobe;
			@(negedge clk_sys);
		end
		sd = sd | meas_diff_strobe;
		chk("diff", sd, 1);
		n = 0;
		while (poll_extend === 1'b1 && n < 64)
		begin
			n++;
			@(negedge clk_sys);
		end
		chk("ext_len", 35'(n), 35'(EXT));
		chk("level", meas_level_strobe, 1);
		wake_event = 1'b1;
		@(negedge clk_sys);
		wake_event = 1'b0;
		@(negedge clk_sys);
		chk("lpm_off", low_power_mode, 0);
		chk("deb_kept", gnd_wake_debounce, 21'h1f_ffff);
		chk("sel_kept", analog_mux_output_sel, 35'h20);
		pa = ADDR_GND_STATUS;
		prw = 1'b0;
		pd = {1'b0, ground_switch_inputs & ~21'h00_0020};
		op(ADDR_GND_DEBOUNCE, 1'b0, 24'h00_0000, 22'h1f_ffff, "wake");
		op(ADDR_ANALOG_MUX_OUTPUT_CTRL, 1'b0, 24'h00_0000, 22'h00_0006, "after");
	endtask : t_lpm

	// =====================================
	// Main sequence and watchdog
	initial
	begin
		rst = 1'b1;
		ground_switch_inputs = 21'h15_a5a5;
		programmable_switch_inputs = 12'ha5c;
		fault_flags = 8'h10;
		interrupt_event = 1'b0;
		wake_event = 1'b0;
		poll_window_end = 1'b0;
		pa = ADDR_GND_STATUS;
		prw = 1'b0;
		pd = {1'b0, 21'h15_a5a5};
		iexp = 1'b1;
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		t_reset();
		t_first();
		t_deb();
		t_analog_mux_output();
		t_mask();
		t_lpm();
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		complete_run();
	end
endmodule : test_switch_monitor_lpm_analog_mux_output_regs

/* design/switch_monitor_lpm_analog_mux_output_regs.sv */
// SPI register slice: ground wake debounce, low-power entry, analog mux control.
// Assumes SPI pins already synchronous to clk_sys and sclk idle low.
//
// Functional notes
// - Debounce 0: judge change by voltage difference
// - Debounce 1: extend polling current 1.2 ms
// - Debounce register 0x1b, 21 bits, reset zero
// - Response: fault bit23, flag bit22, data below
// - Only the entry command enters low power
// - Configuration kept across low-power exit
// - Entry command: write, all-zero data, no answer
// - First frame after wake returns ground status
// - Exactly one of 35 sources to mux for codes 1-35, none for other codes
// - Analog-selected input reads zero in status
// - Analog source current is always pull-up
// - Mux control writable anytime in normal mode
// - Mux register 0x1d: bit6 current, chan 5:0
// - Current select 0 high-Z, 1 wetting
// - Codes 1-21 ground, 22-33 programmable
// - Codes 34, 35 temperature and battery
// - Interrupt flag set on event and reset
// - Fault summary is OR of fault flags
`timescale 1ns/1ps

module switch_monitor_lpm_analog_mux_output_regs
	import switch_monitor_pkg::*;
#(
	parameter int FAULT_W = 8,
	parameter int EXTEND_CYCLES = int'($ceil(EXTEND_TIME_MS * NS_PER_MS / CLK_PERIOD_NS))
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic [GND_CH-1:0] ground_switch_inputs,
	input wire logic [PRG_CH-1:0] programmable_switch_inputs,
	input wire logic [FAULT_W-1:0] fault_flags,
	input wire logic interrupt_event,
	input wire logic wake_event,
	input wire logic poll_window_end,
	output logic low_power_mode,
	output logic poll_extend,
	output logic meas_diff_strobe,
	output logic meas_level_strobe,
	output logic [GND_CH-1:0] gnd_wake_debounce,
	output logic [ANALOG_MUX_OUTPUT_SRC-1:0] analog_mux_output_sel,
	output logic wetting_current_en,
	output logic interrupt_flag_bit
);

	// =====================================
	// Channel decode
	// Code to one-hot source; out-of-range codes select nothing
	function automatic logic [ANALOG_MUX_OUTPUT_SRC-1:0] analog_mux_output_decode(input logic [5:0] chan);
		logic [ANALOG_MUX_OUTPUT_SRC-1:0] sel;
		sel = '0;
		if (chan >= SEL_GND_FIRST && chan <= SEL_BATT)
		begin
			sel[chan - SEL_GND_FIRST] = 1'b1;
		end
		return sel;
	endfunction : analog_mux_output_decode

	state_s s;
	state_s s_next;
	spi_word_s resp;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic normal_mode;
	logic frame_done;
	logic lpm_cmd;
	logic [ANALOG_MUX_OUTPUT_SRC-1:0] sel;
	logic [GND_CH-1:0] gnd_masked;
	logic [PRG_CH-1:0] prg_masked;

	// =====================================
	// Pin edges and frame decode
	assign normal_mode = (s.mode == MODE_NORMAL);
	assign cs_fall = s.cs_n_q & ~spi_cs_n;
	assign cs_rise = ~s.cs_n_q & spi_cs_n;
	assign sclk_rise = ~s.sclk_q & spi_sclk & ~spi_cs_n;
	assign sclk_fall = s.sclk_q & ~spi_sclk & ~spi_cs_n;
	assign frame_done = cs_rise && normal_mode && (s.bit_cnt == FRAME_BITS);
	assign lpm_cmd = (s.shift_in.addr == ADDR_LPM_ENTRY) && s.shift_in.rw
		&& (s.shift_in.data == LPM_CMD_DATA);

	// Selected analog input reads as open
	assign sel = analog_mux_output_decode(s.analog_mux_output.chan);
	assign gnd_masked = ground_switch_inputs & ~sel[GND_CH-1:0];
	assign prg_masked = programmable_switch_inputs & ~sel[GND_CH+PRG_CH-1:GND_CH];

	// =====================================
	// Response word for the next frame
	always_comb
	begin
		resp = '0;
		resp.fault = |fault_flags;
		resp.int_flag = s.int_flag;
		if (s.first_pending)
		begin
			resp.addr = ADDR_GND_STATUS;
			resp.data = 22'(gnd_masked);
		end
		else
		begin
			resp.addr = s.last_addr;
			resp.rw = s.last_rw;
			if (s.last_addr == ADDR_GND_DEBOUNCE)
			begin
				resp.data = 22'(s.debounce);
			end
			else if (s.last_addr == ADDR_ANALOG_MUX_OUTPUT_CTRL)
			begin
				resp.data = 22'(s.analog_mux_output);
			end
			else if (s.last_addr == ADDR_GND_STATUS)
			begin
				resp.data = 22'(gnd_masked);
			end
			else if (s.last_addr == ADDR_PRG_STATUS)
			begin
				resp.data = 22'(prg_masked);
			end
			else
			begin
				resp.data = '0;
			end
		end
	end

	// =====================================
	// Next state
	always_comb
	begin
		s_next = s;
		s_next.sclk_q = spi_sclk;
		s_next.cs_n_q = spi_cs_n;
		s_next.meas_diff = 1'b0;
		s_next.meas_level = 1'b0;

		// Serial shifting, normal mode only
		if (normal_mode)
		begin
			if (cs_fall)
			begin
				s_next.bit_cnt = '0;
				s_next.shift_out = resp;
			end
			else if (sclk_rise && s.bit_cnt != FRAME_BITS)
			begin
				s_next.shift_in = {s.shift_in[30:0], spi_mosi};
				s_next.bit_cnt = s.bit_cnt + 6'h01;
			end
			else if (sclk_fall)
			begin
				s_next.shift_out = {s.shift_out[30:0], 1'b0};
			end
		end

		// Command execution at the end of a full frame
		if (frame_done)
		begin
			s_next.last_addr = s.shift_in.addr;
			s_next.last_rw = s.shift_in.rw;
			s_next.first_pending = 1'b0;
			s_next.int_flag = 1'b0;
			if (s.shift_in.rw && s.shift_in.addr == ADDR_GND_DEBOUNCE)
			begin
				s_next.debounce = s.shift_in.data[GND_CH-1:0];
			end
			else if (s.shift_in.rw && s.shift_in.addr == ADDR_ANALOG_MUX_OUTPUT_CTRL)
			begin
				s_next.analog_mux_output = s.shift_in.data[6:0];
			end
			else if (lpm_cmd)
			begin
				s_next.mode = MODE_LPM;
			end
		end

		// Low-power polling measurement
		if (s.mode == MODE_LPM && poll_window_end)
		begin
			s_next.meas_diff = 1'b1;
			if (|s.debounce)
			begin
				s_next.mode = MODE_EXTEND;
				s_next.ext_cnt = '0;
			end
		end
		else if (s.mode == MODE_EXTEND)
		begin
			s_next.ext_cnt = s.ext_cnt + 1'b1;
			if (s.ext_cnt == EXT_CNT_W'(EXTEND_CYCLES - 1))
			begin
				s_next.meas_level = 1'b1;
				s_next.mode = MODE_LPM;
			end
		end

		// Wake keeps all configuration
		if (!normal_mode && wake_event)
		begin
			s_next.mode = MODE_NORMAL;
			s_next.first_pending = 1'b1;
			s_next.meas_level = 1'b0;
		end

		// Event set wins over the frame clear
		if (interrupt_event)
		begin
			s_next.int_flag = 1'b1;
		end

		if (rst)
		begin
			s_next = '0;
			s_next.mode = MODE_NORMAL;
			s_next.debounce = DEBOUNCE_RESET;
			s_next.analog_mux_output = ANALOG_MUX_OUTPUT_RESET;
			s_next.int_flag = 1'b1;
			s_next.first_pending = 1'b1;
			s_next.sclk_q = 1'b0;
			s_next.cs_n_q = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_sys)
	begin
		s <= s_next;
	end

	// =====================================
	// Outputs
	assign spi_miso = s.shift_out.addr[6];
	assign spi_miso_oe = ~s.cs_n_q & normal_mode;
	assign low_power_mode = ~normal_mode;
	assign poll_extend = (s.mode == MODE_EXTEND);
	assign meas_diff_strobe = s.meas_diff;
	assign meas_level_strobe = s.meas_level;
	assign gnd_wake_debounce = s.debounce;
	assign analog_mux_output_sel = sel;
	// Source current, always a pull-up, only on a real input
	assign wetting_current_en = s.analog_mux_output.cur_sel && (|sel[GND_CH+PRG_CH-1:0]);
	assign interrupt_flag_bit = s.int_flag;

	// =====================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence poll_end_lpm;
		poll_window_end && (s.mode == MODE_LPM) && !wake_event;
	endsequence

	sequence woke_up;
		$fell(low_power_mode);
	endsequence

	sequence frame_load;
		cs_fall && normal_mode;
	endsequence

	chk_lpm_only_cmd: assert property ($rose(low_power_mode) |-> $past(frame_done && lpm_cmd))
		else $error("low power entered without entry command");

	chk_lpm_cmd_data: assert property (frame_done && s.shift_in.addr == ADDR_LPM_ENTRY
		&& s.shift_in.data != LPM_CMD_DATA |=> !low_power_mode)
		else $error("low power entered on nonzero data");

	chk_debounce_write: assert property (frame_done && s.shift_in.rw && s.shift_in.addr == ADDR_GND_DEBOUNCE
		|=> gnd_wake_debounce == $past(s.shift_in.data[GND_CH-1:0]))
		else $error("debounce write not stored");

	chk_analog_mux_output_write: assert property (frame_done && s.shift_in.rw && s.shift_in.addr == ADDR_ANALOG_MUX_OUTPUT_CTRL
		|=> s.analog_mux_output == $past(s.shift_in.data[6:0]))
		else $error("mux control write not stored");

	chk_analog_mux_output_onehot: assert property ($onehot0(analog_mux_output_sel))
		else $error("more than one analog source");

	chk_analog_mux_output_first: assert property (s.analog_mux_output.chan == SEL_GND_FIRST |-> analog_mux_output_sel[0])
		else $error("code one not first ground input");

	chk_analog_mux_output_temp: assert property (s.analog_mux_output.chan == SEL_TEMP |-> analog_mux_output_sel[SRC_TEMP])
		else $error("temperature source not routed");

	chk_analog_mux_output_batt: assert property (s.analog_mux_output.chan == SEL_BATT |-> analog_mux_output_sel[SRC_BATT])
		else $error("battery source not routed");

	chk_analog_mux_output_none: assert property (s.analog_mux_output.chan == SEL_NONE || s.analog_mux_output.chan > SEL_BATT
		|-> analog_mux_output_sel == '0)
		else $error("source routed for empty code");

	chk_hiz_default: assert property (!s.analog_mux_output.cur_sel |-> !wetting_current_en)
		else $error("current on while high impedance");

	chk_diff_meas: assert property (poll_end_lpm |=> meas_diff_strobe)
		else $error("difference measurement missing");

	chk_extend_start: assert property (poll_end_lpm ##0 (|gnd_wake_debounce) |=> poll_extend)
		else $error("extension not started");

	chk_extend_end: assert property (meas_level_strobe
		|-> $past(poll_extend) && $past(s.ext_cnt) == EXT_CNT_W'(EXTEND_CYCLES - 1))
		else $error("extension length wrong");

	chk_normal_nopoll: assert property (normal_mode |-> !poll_extend && !meas_level_strobe)
		else $error("debounce active in normal mode");

	chk_keep_cfg: assert property (woke_up |-> $stable(gnd_wake_debounce) && $stable(s.analog_mux_output))
		else $error("configuration changed on wake");

	chk_wake_first: assert property (woke_up |-> s.first_pending)
		else $error("wake did not arm status answer");

	chk_first_resp: assert property (frame_load ##0 s.first_pending
		|=> s.shift_out.addr == ADDR_GND_STATUS)
		else $error("first answer not ground status");

	chk_fault_sum: assert property (frame_load |=> s.shift_out.fault == $past(|fault_flags))
		else $error("fault summary wrong");

	chk_int_set: assert property (interrupt_event |=> interrupt_flag_bit)
		else $error("interrupt flag not set");

	chk_mask_sel: assert property (frame_load ##0 (s.first_pending || s.last_addr == ADDR_GND_STATUS)
		|=> (s.shift_out.data[GND_CH-1:0] & analog_mux_output_sel[GND_CH-1:0]) == '0)
		else $error("selected input not reported open");

endmodule : switch_monitor_lpm_analog_mux_output_regs

/* design/switch_monitor_pkg.sv */
// Shared constants and types for the switch monitor register slice.
// Assumes a single clk_sys domain and 32-bit SPI frames, MSB first.
package switch_monitor_pkg;

	// =====================================
	// Register addresses (7-bit SPI field)
	localparam logic [6:0] ADDR_GND_DEBOUNCE = 7'h1b;
	localparam logic [6:0] ADDR_LPM_ENTRY = 7'h1c;
	localparam logic [6:0] ADDR_ANALOG_MUX_OUTPUT_CTRL = 7'h1d;
	localparam logic [6:0] ADDR_PRG_STATUS = 7'h1e;
	localparam logic [6:0] ADDR_GND_STATUS = 7'h1f;

	// =====================================
	// Channel counts and frame length
	localparam int GND_CH = 21;
	localparam int PRG_CH = 12;
	localparam int ANALOG_MUX_OUTPUT_SRC = 35;
	localparam logic [5:0] FRAME_BITS = 6'h20;

	// =====================================
	// Analog channel codes
	localparam logic [5:0] SEL_NONE = 6'h00;
	localparam logic [5:0] SEL_GND_FIRST = 6'h01;
	localparam logic [5:0] SEL_TEMP = 6'h22;
	localparam logic [5:0] SEL_BATT = 6'h23;
	localparam int SRC_TEMP = 33;
	localparam int SRC_BATT = 34;

	// =====================================
	// Reset values
	localparam logic [20:0] DEBOUNCE_RESET = 21'h00_0000;
	localparam logic [6:0] ANALOG_MUX_OUTPUT_RESET = 7'h00;
	localparam logic [23:0] LPM_CMD_DATA = 24'h00_0000;

	// =====================================
	// Debounce extension timing
	localparam real EXTEND_TIME_MS = 1.2;
	localparam real CLK_PERIOD_NS = 8.0;
	localparam real NS_PER_MS = 1.0e6;
	localparam int EXT_CNT_W = 18;

	// =====================================
	// Carriers
	typedef struct packed {
		logic [6:0] addr;
		logic rw;
		logic [23:0] data;
	} spi_cmd_s;

	typedef struct packed {
		logic [6:0] addr;
		logic rw;
		logic fault;
		logic int_flag;
		logic [21:0] data;
	} spi_word_s;

	typedef struct packed {
		logic cur_sel;
		logic [5:0] chan;
	} analog_mux_output_ctrl_s;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b001,
		MODE_LPM = 3'b010,
		MODE_EXTEND = 3'b100
	} mode_e;

	typedef struct packed {
		mode_e mode;
		logic [20:0] debounce;
		analog_mux_output_ctrl_s analog_mux_output;
		logic int_flag;
		logic first_pending;
		spi_cmd_s shift_in;
		spi_word_s shift_out;
		logic [5:0] bit_cnt;
		logic sclk_q;
		logic cs_n_q;
		logic [6:0] last_addr;
		logic last_rw;
		logic [EXT_CNT_W-1:0] ext_cnt;
		logic meas_diff;
		logic meas_level;
	} state_s;

endpackage : switch_monitor_pkg
